/* File: core/pbz_top.sv */
// Pulse-width and tone generator with its APB register file and pin muxes.
// Assumes an APB master on pclk at 10 MHz and port latches outside.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Pulse low n ticks per sub-period
// - Frame repeats every 4096 ticks
// - Frame split into sixteen sub-periods
// - Selected sub-periods get n+1 ticks low
// - Low four bits choose extra-pulse sub-periods
// - Bit weights map to bit-reversed sub-periods
// - First sub-period never gets extra tick
// - Tone is 75 kHz over 2n, square
// - Divisor zero holds low, one holds high
// - Tone enable routes tone to port3 pin
// - Transfer bit copies divisor into tone latch
// - Data port spans four channel codes
// - Reset clears tone pin enable
// - Tone: 8-bit divider then divide-by-two
// - Pulse load waits for frame end
// - Pulse enable routes pulse to port2 pin
// - Counter, latch and comparator make pulse
module pbz_top
    import pbz_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Ordinary port values for the shared pins.
    input  wire logic        port2_bit3_out,
    input  wire logic        port3_bit3_out,
    // Shared pins.
    output logic             port2_bit3_pin,
    output logic             port3_bit3_pin
);
    pbz_ctl_t          ctl_reg;
    pbz_ctl_t          ctl_next;
    logic [PWM_W-1:0]  pbuf_reg;
    logic [PWM_W-1:0]  pbuf_next;
    logic [TONE_W-1:0] tbuf_reg;
    logic [TONE_W-1:0] tbuf_next;
    logic [TONE_W-1:0] tlat_reg;
    logic [TONE_W-1:0] tlat_next;
    logic [31:0]       rdata_reg;
    logic [31:0]       rdata_next;
    logic [23:0]       acc_reg;
    logic [23:0]       acc_next;
    logic              base_reg;
    logic              base_next;
    logic              half_reg;
    logic              half_next;
    logic              tick_reg;
    logic              tick_next;
    logic              p2_reg;
    logic              p2_next;
    logic              p3_reg;
    logic              p3_next;

    logic [5:0]        idx;
    logic              mapped;
    logic              setup;
    logic              wr;
    logic              is_data;
    logic              tone_load;
    logic [24:0]       acc_sum;
    logic              pulse_out;
    logic              tone_out;
    logic [PWM_W-1:0]  plat;
    logic [PORT_CH*NIB_W-1:0] pdata_wide;
    logic [PORT_CH*NIB_W-1:0] tdata_wide;
    logic [PORT_CH*NIB_W-1:0] pbuf_ext;
    logic [PORT_CH*NIB_W-1:0] tbuf_ext;

    // Bus decode.
    assign idx     = paddr[7:2];
    assign is_data = (idx < IDX_CTRL) && (idx >= IDX_DATA0);
    assign mapped  = (paddr[1:0] == BYTE_ALIGN) && (idx <= IDX_TLAT);
    assign setup   = psel && !penable;
    assign wr      = psel && penable && pwrite && mapped;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = rdata_reg;

    // Buffers padded to the full four-nibble port width.
    assign pbuf_ext = {4'h0, pbuf_reg};
    assign tbuf_ext = {8'h00, tbuf_reg};

    // Channel codes 0-2 write one nibble of the pulse buffer and codes 0-1 one nibble of the tone buffer, chosen by the select bit; other codes are dropped.
    genvar ch;
    generate
        for (ch = 0; ch < PORT_CH; ch++) begin : g_nib
            always_comb begin
                pdata_wide[ch*NIB_W +: NIB_W] = pbuf_ext[ch*NIB_W +: NIB_W];
                tdata_wide[ch*NIB_W +: NIB_W] = tbuf_ext[ch*NIB_W +: NIB_W];
                if (wr && is_data && idx[1:0] == 2'(ch)) begin
                    if (ctl_reg.pulse_tone_select) begin
                        pdata_wide[ch*NIB_W +: NIB_W] = pwdata[NIB_W-1:0];
                    end else begin
                        tdata_wide[ch*NIB_W +: NIB_W] = pwdata[NIB_W-1:0];
                    end
                end
            end
        end
    endgenerate

    assign tone_load = wr && (idx == IDX_CTRL) && pwdata[1] && !pwdata[0];

    // Register file next values.
    always_comb begin
        ctl_next  = ctl_reg;
        pbuf_next = pdata_wide[PWM_W-1:0];
        tbuf_next = tdata_wide[TONE_W-1:0];
        tlat_next = tlat_reg;
        if (wr && idx == IDX_CTRL) begin
            ctl_next = pwdata[3:0];
        end
        if (tone_load) begin
            tlat_next = tbuf_reg;
        end
    end

    // Read data is captured in the setup cycle so the access phase needs no wait.
    always_comb begin
        rdata_next = rdata_reg;
        if (setup && !pwrite) begin
            rdata_next = 32'h0000_0000;
            if (is_data) begin
                rdata_next[3:0] = ctl_reg.pulse_tone_select ?
                    pdata_wide[idx[1:0]*NIB_W +: NIB_W] :
                    tdata_wide[idx[1:0]*NIB_W +: NIB_W];
            end else if (idx == IDX_CTRL) begin
                rdata_next[3:0] = ctl_reg;
            end else if (idx == IDX_STAT) begin
                rdata_next[2:0] = {ctl_reg.buffer_transfer && ctl_reg.pulse_tone_select,
                                   pulse_out, tone_out};
            end else if (idx == IDX_PLAT) begin
                rdata_next[PWM_W-1:0] = plat;
            end else if (idx == IDX_TLAT) begin
                rdata_next[TONE_W-1:0] = tlat_reg;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg   <= CTL_RST;
            pbuf_reg  <= PLAT_RST;
            tbuf_reg  <= TLAT_RST;
            tlat_reg  <= TLAT_RST;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ctl_reg   <= ctl_next;
            pbuf_reg  <= pbuf_next;
            tbuf_reg  <= tbuf_next;
            tlat_reg  <= tlat_next;
            rdata_reg <= rdata_next;
        end
    end

    // Fractional divider: 75 kHz base strobe on average, tick on every second one.
    assign acc_sum = {1'b0, acc_reg} + {1'b0, ACC_STEP};

    always_comb begin
        acc_next  = acc_sum[23:0];
        base_next = 1'b0;
        half_next = half_reg;
        tick_next = 1'b0;
        if (acc_sum >= {1'b0, ACC_WRAP}) begin
            acc_next  = 24'(acc_sum - {1'b0, ACC_WRAP});
            base_next = 1'b1;
            half_next = !half_reg;
            tick_next = half_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg  <= 24'h000000;
            base_reg <= 1'b0;
            half_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            acc_reg  <= acc_next;
            base_reg <= base_next;
            half_reg <= half_next;
            tick_reg <= tick_next;
        end
    end

    // The pulse latch keeps asking while the transfer and select bits stay set; clearing either cancels.
    pbz_pwm u_pwm (
        .clk       (pclk),
        .rstn      (presetn),
        .tick      (tick_reg),
        .load_req  (ctl_reg.buffer_transfer && ctl_reg.pulse_tone_select),
        .data      (pbuf_reg),
        .pulse_out (pulse_out),
        .latch     (plat)
    );

    pbz_tone u_tone (
        .clk      (pclk),
        .rstn     (presetn),
        .base_en  (base_reg),
        .divisor  (tlat_reg),
        .tone_out (tone_out)
    );

    // Pin multiplexers.
    always_comb begin
        p2_next = ctl_reg.pulse_pin_enable ? pulse_out : port2_bit3_out;
        p3_next = ctl_reg.tone_pin_enable ? tone_out : port3_bit3_out;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p2_reg <= 1'b0;
            p3_reg <= 1'b0;
        end else begin
            p2_reg <= p2_next;
            p3_reg <= p3_next;
        end
    end

    assign port2_bit3_pin = p2_reg;
    assign port3_bit3_pin = p3_reg;

    sequence s_tone_xfer;
        tone_load ##1 1'b1;
    endsequence
    property p_tone_load;
        @(posedge pclk) disable iff (!presetn) s_tone_xfer |-> tlat_reg == $past(tbuf_reg);
    endproperty
    a_tone_load: assert property (p_tone_load) else $error("tone latch not loaded");
    property p_tone_pin;
        @(posedge pclk) disable iff (!presetn)
            ctl_reg.tone_pin_enable |=> port3_bit3_pin == $past(tone_out);
    endproperty
    a_tone_pin: assert property (p_tone_pin) else $error("tone not on port3 pin");
    property p_pulse_pin;
        @(posedge pclk) disable iff (!presetn)
            ctl_reg.pulse_pin_enable |=> port2_bit3_pin == $past(pulse_out);
    endproperty
    a_pulse_pin: assert property (p_pulse_pin) else $error("pulse not on port2 pin");
    property p_tick_rate;
        @(posedge pclk) disable iff (!presetn) tick_reg |=> !tick_reg [*8];
    endproperty
    a_tick_rate: assert property (p_tick_rate) else $error("tick too fast");
    property p_tick_base;
        @(posedge pclk) disable iff (!presetn)
            tick_reg |-> base_reg;
    endproperty
    a_tick_base: assert property (p_tick_base) else $error("tick off the base strobe");
    property p_base_rate;
        @(posedge pclk) disable iff (!presetn)
            base_reg |=> !base_reg [*8];
    endproperty
    a_base_rate: assert property (p_base_rate) else $error("base strobe too fast");

    // Bus-side checks, then the idle port pin checks.
    property p_ctl_write;
        @(posedge pclk) disable iff (!presetn)
            wr && idx == IDX_CTRL |=> ctl_reg == $past(pwdata[3:0]);
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("control write lost");
    property p_err_ignored;
        @(posedge pclk) disable iff (!presetn)
            psel && penable && pwrite && !mapped |=> $stable(ctl_reg) && $stable(pbuf_reg) && $stable(tbuf_reg);
    endproperty
    a_err_ignored: assert property (p_err_ignored) else $error("refused write changed state");
    property p_tone_keep;
        @(posedge pclk) disable iff (!presetn)
            !tone_load |=> $stable(tlat_reg);
    endproperty
    a_tone_keep: assert property (p_tone_keep) else $error("tone latch changed without transfer");
    property p_pulse_side;
        @(posedge pclk) disable iff (!presetn)
            wr && is_data && ctl_reg.pulse_tone_select |=> $stable(tbuf_reg);
    endproperty
    a_pulse_side: assert property (p_pulse_side) else $error("pulse data reached tone buffer");
    property p_tone_side;
        @(posedge pclk) disable iff (!presetn)
            wr && is_data && !ctl_reg.pulse_tone_select |=> $stable(pbuf_reg);
    endproperty
    a_tone_side: assert property (p_tone_side) else $error("tone data reached pulse buffer");
    property p_port2_idle;
        @(posedge pclk) disable iff (!presetn)
            !ctl_reg.pulse_pin_enable |=> port2_bit3_pin == $past(port2_bit3_out);
    endproperty
    a_port2_idle: assert property (p_port2_idle) else $error("port2 pin lost its port value");
    property p_port3_idle;
        @(posedge pclk) disable iff (!presetn)
            !ctl_reg.tone_pin_enable |=> port3_bit3_pin == $past(port3_bit3_out);
    endproperty
    a_port3_idle: assert property (p_port3_idle) else $error("port3 pin lost its port value");
endmodule : pbz_top
`default_nettype wire

/* File: core/pbz_pkg.sv */
// Shared constants and types for the pulse-width and tone generator.
// Assumes a 10 MHz pclk and an APB master with 32-bit data.
package pbz_pkg;
    localparam int unsigned CLK_HZ   = 10_000_000;
    localparam int unsigned BASE_HZ  = 75_000;
    localparam int unsigned TICK_HZ  = 37_500;
    localparam int unsigned TICK_DIV = BASE_HZ / TICK_HZ;
    localparam logic [23:0] ACC_WRAP = 24'(CLK_HZ);
    localparam logic [23:0] ACC_STEP = 24'(BASE_HZ);

    localparam int unsigned PWM_W    = 12;
    localparam int unsigned TONE_W   = 8;
    localparam int unsigned NIB_W    = 4;
    localparam int unsigned PORT_CH  = 4;
    localparam int unsigned SUB_N    = 16;
    localparam logic [11:0] FRAME_LAST = 12'hFFF;

    localparam logic [5:0]  IDX_DATA0 = 6'h00;
    localparam logic [5:0]  IDX_CTRL  = 6'h04;
    localparam logic [5:0]  IDX_STAT  = 6'h05;
    localparam logic [5:0]  IDX_PLAT  = 6'h06;
    localparam logic [5:0]  IDX_TLAT  = 6'h07;
    localparam logic [1:0]  BYTE_ALIGN = 2'h0;

    localparam logic [7:0]  TONE_LOW  = 8'h00;
    localparam logic [7:0]  TONE_HIGH = 8'h01;

    typedef struct packed {
        logic tone_pin_enable;
        logic pulse_pin_enable;
        logic buffer_transfer;
        logic pulse_tone_select;
    } pbz_ctl_t;

    localparam pbz_ctl_t CTL_RST = 4'h0;
    localparam logic [PWM_W-1:0]  PLAT_RST = 12'h000;
    localparam logic [TONE_W-1:0] TLAT_RST = 8'h00;
endpackage : pbz_pkg

/* File: core/pbz_tone.sv */
// Tone divider: programmable divide-by-n counter and a divide-by-two stage.
// Assumes base_en is a one-cycle strobe at the 75 kHz base rate.
`timescale 1ns/1ps
`default_nettype none
module pbz_tone
    import pbz_pkg::*;
(
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rstn,
    // Base rate and divisor from the holding latch.
    input  wire logic              base_en,
    input  wire logic [TONE_W-1:0] divisor,
    // Square wave.
    output logic                   tone_out
);
    logic [TONE_W-1:0] cnt_reg;
    logic [TONE_W-1:0] cnt_next;
    logic              out_reg;
    logic              out_next;

    always_comb begin
        cnt_next = cnt_reg;
        out_next = out_reg;
        if (divisor == TONE_LOW) begin
            cnt_next = divisor;
            out_next = 1'b0;
        end else if (divisor == TONE_HIGH) begin
            cnt_next = divisor;
            out_next = 1'b1;
        end else if (base_en) begin
            if (cnt_reg <= TONE_HIGH) begin
                cnt_next = divisor;
                out_next = !out_reg;
            end else begin
                cnt_next = cnt_reg - TONE_HIGH;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 8'h00;
            out_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end

    assign tone_out = out_reg;

    sequence s_zero_held;
        (divisor == TONE_LOW) [*2];
    endsequence
    property p_tone_zero;
        @(posedge clk) disable iff (!rstn) s_zero_held |=> !tone_out;
    endproperty
    a_tone_zero: assert property (p_tone_zero) else $error("tone not low at divisor 0");
    property p_tone_one;
        @(posedge clk) disable iff (!rstn) divisor == TONE_HIGH |=> tone_out;
    endproperty
    a_tone_one: assert property (p_tone_one) else $error("tone not high at divisor 1");
    property p_tone_toggle;
        @(posedge clk) disable iff (!rstn)
            base_en && divisor > TONE_HIGH && cnt_reg <= TONE_HIGH |=> tone_out != $past(tone_out);
    endproperty
    a_tone_toggle: assert property (p_tone_toggle) else $error("tone missed toggle");
    property p_tone_hold;
        @(posedge clk) disable iff (!rstn)
            !base_en && divisor > TONE_HIGH && $stable(divisor) |=> $stable(tone_out);
    endproperty
    a_tone_hold: assert property (p_tone_hold) else $error("tone changed off strobe");
endmodule : pbz_tone
`default_nettype wire

/* File: core/pbz_pwm.sv */
// Pulse generator: 12-bit frame counter, data latch and comparator.
// Assumes tick is a one-cycle strobe at 37.5 kHz.
`timescale 1ns/1ps
`default_nettype none
module pbz_pwm
    import pbz_pkg::*;
(
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rstn,
    // Tick and load request.
    input  wire logic             tick,
    input  wire logic             load_req,
    input  wire logic [PWM_W-1:0] data,
    // Waveform and latch readback.
    output logic                  pulse_out,
    output logic [PWM_W-1:0]      latch
);
    logic [PWM_W-1:0] cnt_reg;
    logic [PWM_W-1:0] cnt_next;
    logic [PWM_W-1:0] lat_reg;
    logic [PWM_W-1:0] lat_next;
    logic             out_reg;
    logic             out_next;
    logic [3:0]       sub;
    logic [7:0]       pos;
    logic [7:0]       width;
    logic [3:0]       pick;
    logic             extra;
    logic             frame_end;

    assign sub   = cnt_reg[11:8];
    assign pos   = cnt_reg[7:0];
    assign width = lat_reg[11:4];
    assign pick  = lat_reg[3:0];

    always_comb begin
        extra = 1'b0;
        if (sub[0]) begin
            extra = pick[3];
        end else if (sub[1:0] == 2'h2) begin
            extra = pick[2];
        end else if (sub[2:0] == 3'h4) begin
            extra = pick[1];
        end else if (sub == 4'h8) begin
            extra = pick[0];
        end
    end

    assign frame_end = tick && (cnt_reg == FRAME_LAST);

    always_comb begin
        cnt_next = tick ? cnt_reg + 12'h001 : cnt_reg;
        lat_next = (frame_end && load_req) ? data : lat_reg;
        // Low from the start of the sub-period for n or n+1 ticks.
        out_next = !({1'b0, pos} < ({1'b0, width} + {8'h00, extra}));
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 12'h000;
            lat_reg <= PLAT_RST;
            out_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_next;
            lat_reg <= lat_next;
            out_reg <= out_next;
        end
    end

    assign pulse_out = out_reg;
    assign latch     = lat_reg;

    property p_pulse_low;
        @(posedge clk) disable iff (!rstn) pos < width |=> !pulse_out;
    endproperty
    a_pulse_low: assert property (p_pulse_low) else $error("pulse not low inside width");
    property p_pulse_high;
        @(posedge clk) disable iff (!rstn) pos > width |=> pulse_out;
    endproperty
    a_pulse_high: assert property (p_pulse_high) else $error("pulse low past width");
    property p_sub0_plain;
        @(posedge clk) disable iff (!rstn) sub == 4'h0 && pos == width |=> pulse_out;
    endproperty
    a_sub0_plain: assert property (p_sub0_plain) else $error("extra pulse in first sub-period");
    property p_odd_extra;
        @(posedge clk) disable iff (!rstn) sub[0] && pick[3] && pos == width |=> !pulse_out;
    endproperty
    a_odd_extra: assert property (p_odd_extra) else $error("odd sub-period lacks extra tick");
    property p_latch_frame;
        @(posedge clk) disable iff (!rstn) !(frame_end && load_req) |=> $stable(lat_reg);
    endproperty
    a_latch_frame: assert property (p_latch_frame) else $error("latch changed mid frame");
endmodule : pbz_pwm
`default_nettype wire

/* File: tb/pbz_far_model.sv */
// Far-side model: the low-pass filter and the buzzer timing the shared pins.
// Assumes pclk at 10 MHz; widths come out in ticks and in 75 kHz base periods.
`timescale 1ns/1ps
`default_nettype none
module pbz_far_model (
    // Clock and reset.
    input  wire logic   pclk,
    input  wire logic   presetn,
    // Pins seen by the filter and the buzzer.
    input  wire logic   port2_bit3_pin,
    input  wire logic   port3_bit3_pin,
    // Last low pulse in ticks, last tone half period in base periods.
    output logic [15:0] low_ticks,
    output logic        low_stb,
    output logic [15:0] half_units,
    output logic        half_stb
);
    logic [19:0] low_cnt;
    logic [19:0] half_cnt;
    logic        p2_q;
    logic        p3_q;

    // Widths are rounded because a base period is 133 or 134 clock cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt    <= 20'h0;
            half_cnt   <= 20'h0;
            p2_q       <= 1'b0;
            p3_q       <= 1'b0;
            low_ticks  <= 16'h0;
            low_stb    <= 1'b0;
            half_units <= 16'h0;
            half_stb   <= 1'b0;
        end else begin
            p2_q     <= port2_bit3_pin;
            p3_q     <= port3_bit3_pin;
            low_stb  <= 1'b0;
            half_stb <= 1'b0;
            low_cnt  <= port2_bit3_pin ? 20'h0 : low_cnt + 20'h1;
            half_cnt <= (port3_bit3_pin != p3_q) ? 20'h1 : half_cnt + 20'h1;
            if (port2_bit3_pin && !p2_q) begin
                low_stb   <= 1'b1;
                low_ticks <= 16'((low_cnt * 32'h3 + 32'h190) / 32'h320);
            end
            if (port3_bit3_pin != p3_q) begin
                half_stb   <= 1'b1;
                half_units <= 16'((half_cnt * 32'h3 + 32'hC8) / 32'h190);
            end
        end
    end
endmodule : pbz_far_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the pulse-width and tone generator over APB.
// Assumes pbz_pkg and pbz_top compiled first; the far-side model times the pins.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pbz_pkg::*;
    logic        pclk;
    logic        presetn;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        port2_bit3_out;
    logic        port3_bit3_out;
    logic        port2_bit3_pin;
    logic        port3_bit3_pin;
    logic [15:0] half_units;
    logic        half_stb;
    logic        low_stb;
    logic [32:0] exp_q[$];
    logic [31:0] r;
    logic [7:0]  tone_tab [5];
    logic [11:0] pd;
    int          err_count = 0;
    int          samples_checked = 0;
    int          seed = 34;
    int          lows = 0;
    int          halves = 0;
    int          base;

    pbz_top dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port2_bit3_out(port2_bit3_out), .port3_bit3_out(port3_bit3_out),
        .port2_bit3_pin(port2_bit3_pin), .port3_bit3_pin(port3_bit3_pin)
    );
    pbz_far_model far_u (
        .pclk(pclk), .presetn(presetn), .port2_bit3_pin(port2_bit3_pin),
        .port3_bit3_pin(port3_bit3_pin), .low_ticks(), .low_stb(low_stb),
        .half_units(half_units), .half_stb(half_stb)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic results();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    // One transfer; the expected error flag and read data go to the queue.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        exp_q.push_back(e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask : rd

    task automatic wait_half();
        do @(posedge pclk); while (half_stb !== 1'b1);
    endtask : wait_half

    task automatic port_check();
        repeat (4) begin
            @(posedge pclk);
            r = $random(seed);
            port2_bit3_out <= r[0];
            port3_bit3_out <= r[1];
            @(posedge pclk);
            @(negedge pclk);
            check({32'h0, port2_bit3_pin}, {32'h0, r[0]});
            check({32'h0, port3_bit3_pin}, {32'h0, r[1]});
        end
        @(posedge pclk);
    endtask : port_check

    always @(posedge pclk) begin
        if (psel && penable && pready)
            check({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
        if (low_stb)
            lows++;
        if (half_stb)
            halves++;
    end

    initial begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        port2_bit3_out <= 1'b0;
        port3_bit3_out <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd({IDX_CTRL, BYTE_ALIGN}, 32'h0);
        rd(8'h18, 32'h0);
        port_check();
        apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 8'h24, 32'hF, {1'b1, 32'h0});
        apb(1'b0, 8'h11, 32'h0, {1'b1, 32'h0});
        r = $random(seed);
        tone_tab = '{8'h02, 8'h03, 8'h04 + {3'h0, r[4:0]}, 8'h00, 8'h01};
        foreach (tone_tab[i]) begin
            wr(8'h10, 32'h0);
            wr(8'h00, {28'h0, tone_tab[i][3:0]});
            wr(8'h04, {28'h0, tone_tab[i][7:4]});
            rd(8'h04, {28'h0, tone_tab[i][7:4]});
            wr(8'h10, 32'hA);
            rd(8'h1C, {24'h0, tone_tab[i]});
            if (tone_tab[i] < 8'h02) begin
                repeat (4) @(posedge pclk);
                base = halves;
                repeat (1500) @(posedge pclk);
                @(negedge pclk);
                check(33'(halves - base), 33'h0);
                check({32'h0, port3_bit3_pin}, {32'h0, tone_tab[i][0]});
                @(posedge pclk);
            end else begin
                repeat (3) wait_half();
                check({17'h0, half_units}, {25'h0, tone_tab[i]});
                wait_half();
                check({17'h0, half_units}, {25'h0, tone_tab[i]});
            end
        end
        wr(8'h1C, 32'hFF);
        rd(8'h1C, 32'h1);
        r = $random(seed);
        pd = r[11:0];
        wr(8'h10, 32'h5);
        for (int k = 0; k < 3; k++)
            wr({6'(k), 2'h0}, {28'h0, pd[k*4 +: 4]});
        for (int k = 0; k < 3; k++)
            rd({6'(k), 2'h0}, {28'h0, pd[k*4 +: 4]});
        wr(8'h10, 32'h7);
        rd(8'h14, 32'h7);
        base = lows;
        repeat (2000) @(posedge pclk);
        @(negedge pclk);
        check(33'(lows - base), 33'h0);
        check({32'h0, port2_bit3_pin}, 33'h1);
        @(posedge pclk);
        rd(8'h18, 32'h0);
        wr(8'h10, 32'h5);
        rd(8'h14, 32'h3);
        rd(8'h18, 32'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h10, 32'h0);
        port_check();
        results();
    end

    initial begin
        repeat (90000) @(posedge pclk);
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        results();
    end
endmodule : testbench
`default_nettype wire
